// ==== src/ict_consts.vh ====
// constants for the i/o command and test handshake terminal
`ifndef ICT_CONSTS_VH
`define ICT_CONSTS_VH

// ****************************************
// register byte offsets
// ****************************************
`define ICT_OFF_CTRL 4'h0
`define ICT_OFF_UNIT 4'h4
`define ICT_OFF_STAT 4'h8
`define ICT_OFF_FUNC 4'hc
`define ICT_ADDR_W 4

// ****************************************
// control fields and reset values
// ****************************************
`define ICT_CTRL_EN 0
`define ICT_CTRL_RST 1'h0
`define ICT_UNIT_W 6
`define ICT_UNIT_RST 6'h00

// ****************************************
// second word fields, bit 0 is the most significant bus line
// ****************************************
`define ICT_BUS_W 16
`define ICT_FC_HI 11
`define ICT_FC_LO 6
`define ICT_FC_W 6
`define ICT_SU_HI 5
`define ICT_SU_LO 3
`define ICT_SU_W 3
`define ICT_TSEL_W 3
`define ICT_NCOND 8

// ****************************************
// status bit positions
// ****************************************
`define ICT_ST_TEST 0
`define ICT_ST_SYNC 1
`define ICT_ST_STROBE 2
`define ICT_ST_ACCEPT 3
`define ICT_ST_TEU 4
`define ICT_ST_READY 5
`define ICT_ST_W 6

// ****************************************
// bus answers
// ****************************************
`define ICT_RESP_OKAY 2'h0
`define ICT_RESP_SLVERR 2'h2
`define ICT_ZERO32 32'h00000000

`endif

// ==== src/ict_terminal.v ====
// data terminal for the i/o command and test instructions, with register slave
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "ict_consts.vh"

// Behaviour
// - selected command with sync: next clock raises test return if ready, and sync on the same clock
// - skip mode, not ready: test return stays low, sync return still raised
// - dropping instruction sync clears test return and sync return
// - data here latches function bits from bus and raises data accepted
// - mainframe holds data here until accepted; removal drops data accepted
// - instruction sync with unit selected releases return clears, enables clock gate
// - gated clock sets test return only with ready and command level
// - skip mode clock sets sync return; wait mode sets it with test return
// - test return steering sampled every clock; ready sets test and sync at once
// - data here with command and select raises command ready to unit
// - command ready with strobe clear: next clock sets strobe to device
// - device raises command accepted after capturing bits, any delay
// - clock after command accepted resets strobe, which drives data accepted
// - command or test level combined with unit select qualifies every response
// - test instruction is always skip type and device is presumed ready
// - test selects busy, parity, form, inoperative, not busy, file, device conditions
// - wait option travels as first word bit 9; one means wait
// - second word bits 4 to 9 function code, bits 10 to 12 sub-unit
module ict_terminal (
  input wire mclk,
  input wire rst_n,
  input wire instr_sync_n,
  input wire command_external_instr_n,
  input wire test_external_instr_n,
  input wire wait_flag_n,
  input wire data_here_n,
  input wire [`ICT_UNIT_W-1:0] unit_number_n,
  input wire [`ICT_BUS_W-1:0] io_bus_n,
  output wire test_return_n,
  output wire sync_return_n,
  output wire data_accepted_n,
  input wire unit_ready,
  input wire cmd_accepted,
  input wire [`ICT_NCOND-1:0] test_cond,
  output wire cmd_ready_to_unit,
  output wire cmd_strobe,
  output reg [`ICT_FC_W-1:0] function_code,
  output reg [`ICT_SU_W-1:0] sub_unit,
  input wire [`ICT_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`ICT_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ****************************************
  // pin synchronisers; zero volts means asserted
  // ****************************************
  localparam NSYNC = 5 + `ICT_UNIT_W + `ICT_BUS_W;
  reg [NSYNC-1:0] pin_meta;
  reg [NSYNC-1:0] pin_sync;
  wire [NSYNC-1:0] pin_raw;
  assign pin_raw = ~{instr_sync_n, command_external_instr_n, test_external_instr_n,
                     wait_flag_n, data_here_n, unit_number_n, io_bus_n};

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= {NSYNC{1'b0}};
      pin_sync <= {NSYNC{1'b0}};
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  wire instr_sync = pin_sync[NSYNC-1];
  wire command_external_instr = pin_sync[NSYNC-2];
  wire test_external_instr = pin_sync[NSYNC-3];
  wire wait_flag = pin_sync[NSYNC-4];
  wire data_here = pin_sync[NSYNC-5];
  wire [`ICT_UNIT_W-1:0] unit_number = pin_sync[`ICT_BUS_W +: `ICT_UNIT_W];
  wire [`ICT_BUS_W-1:0] io_bus = pin_sync[`ICT_BUS_W-1:0];

  // ****************************************
  // unit select and qualification
  // ****************************************
  reg enable;
  reg [`ICT_UNIT_W-1:0] unit_address;
  wire this_unit = enable && (unit_number == unit_address);
  wire cmd_sel = command_external_instr && this_unit;
  wire teu_sel = test_external_instr && this_unit;
  wire sync_gate = instr_sync && this_unit;

  // ****************************************
  // test return and sync return flops
  // ****************************************
  reg test_return_flop;
  reg sync_return_flop;
  reg teu_result;
  reg data_accepted_flop;
  reg command_strobe_flop;
  reg strobe_done;
  wire set_test = cmd_sel && unit_ready && !test_return_flop;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      test_return_flop <= 1'b0;
      sync_return_flop <= 1'b0;
    end else if (!sync_gate) begin
      // held cleared while the sync level is absent
      test_return_flop <= 1'b0;
      sync_return_flop <= 1'b0;
    end else if (cmd_sel) begin
      // steering looked at on every clock, so a late ready still answers
      if (set_test) begin
        test_return_flop <= 1'b1;
        sync_return_flop <= 1'b1;
      end else if (!wait_flag) begin
        sync_return_flop <= 1'b1;
      end
    end else if (teu_sel) begin
      sync_return_flop <= 1'b1;
    end
  end

  // ****************************************
  // data phase: command strobe and data accepted
  // ****************************************
  assign cmd_ready_to_unit = data_here && cmd_sel;
  wire [`ICT_TSEL_W-1:0] cond_sel = io_bus[`ICT_FC_LO +: `ICT_TSEL_W];

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      command_strobe_flop <= 1'b0;
      strobe_done <= 1'b0;
      data_accepted_flop <= 1'b0;
      teu_result <= 1'b0;
      function_code <= {`ICT_FC_W{1'b0}};
      sub_unit <= {`ICT_SU_W{1'b0}};
    end else if (!data_here) begin
      command_strobe_flop <= 1'b0;
      strobe_done <= 1'b0;
      data_accepted_flop <= 1'b0;
      teu_result <= 1'b0;
    end else if (cmd_sel) begin
      if (!command_strobe_flop && !strobe_done) begin
        command_strobe_flop <= 1'b1;
        function_code <= io_bus[`ICT_FC_HI:`ICT_FC_LO];
        sub_unit <= io_bus[`ICT_SU_HI:`ICT_SU_LO];
      end else if (command_strobe_flop && cmd_accepted) begin
        // device delay is open ended; the strobe simply waits
        command_strobe_flop <= 1'b0;
        strobe_done <= 1'b1;
        data_accepted_flop <= 1'b1;
      end
    end else if (teu_sel && !data_accepted_flop) begin
      function_code <= io_bus[`ICT_FC_HI:`ICT_FC_LO];
      teu_result <= test_cond[cond_sel];
      data_accepted_flop <= 1'b1;
    end
  end

  assign cmd_strobe = command_strobe_flop;
  assign test_return_n = ~(test_return_flop | teu_result);
  assign sync_return_n = ~sync_return_flop;
  assign data_accepted_n = ~data_accepted_flop;

  // ****************************************
  // axi4-lite slave
  // ****************************************
  reg aw_held;
  reg w_held;
  reg [`ICT_ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_ctrl = do_write && (aw_addr == `ICT_OFF_CTRL);
  wire wr_unit = do_write && (aw_addr == `ICT_OFF_UNIT);
  wire wr_known = wr_ctrl || wr_unit || (aw_addr == `ICT_OFF_STAT) ||
                  (aw_addr == `ICT_OFF_FUNC);

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {`ICT_ADDR_W{1'b0}};
      w_data <= `ICT_ZERO32;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ICT_RESP_OKAY;
      enable <= `ICT_CTRL_RST;
      unit_address <= `ICT_UNIT_RST;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `ICT_RESP_OKAY : `ICT_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_ctrl && w_strb[0]) begin
        enable <= w_data[`ICT_CTRL_EN];
      end
      if (wr_unit && w_strb[0]) begin
        unit_address <= w_data[`ICT_UNIT_W-1:0];
      end
    end
  end

  wire [`ICT_ST_W-1:0] status = {unit_ready, teu_result, data_accepted_flop,
                                 command_strobe_flop, sync_return_flop, test_return_flop};

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `ICT_ZERO32;
      s_axi_rresp <= `ICT_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `ICT_RESP_OKAY;
      case (s_axi_araddr)
        `ICT_OFF_CTRL: s_axi_rdata <= {31'h00000000, enable};
        `ICT_OFF_UNIT: s_axi_rdata <= {26'h0000000, unit_address};
        `ICT_OFF_STAT: s_axi_rdata <= {26'h0000000, status};
        `ICT_OFF_FUNC: s_axi_rdata <= {23'h000000, sub_unit, function_code};
        default: begin
          s_axi_rdata <= `ICT_ZERO32;
          s_axi_rresp <= `ICT_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // ict_terminal

// ==== verif/ict_properties.sv ====
// port assertions for the command and test terminal
`timescale 1ns/1ps
module ict_properties (
  input wire mclk,
  input wire rst_n,
  input wire instr_sync_n,
  input wire test_external_instr_n,
  input wire data_here_n,
  input wire test_return_n,
  input wire sync_return_n,
  input wire data_accepted_n,
  input wire unit_ready,
  input wire cmd_accepted,
  input wire cmd_ready_to_unit,
  input wire cmd_strobe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // pin clears go through the synchronisers, hence the short window
  property p_clr;
    $rose(instr_sync_n) && test_external_instr_n |-> ##[1:4] (sync_return_n && test_return_n);
  endproperty
  a_clr: assert property (p_clr) else $error("returns not cleared");
  property p_sync;
    !test_return_n && test_external_instr_n |-> !sync_return_n;
  endproperty
  a_sync: assert property (p_sync) else $error("test return without sync");
  property p_rdy;
    $fell(test_return_n) && data_here_n |-> $past(unit_ready);
  endproperty
  a_rdy: assert property (p_rdy) else $error("test return while not ready");
  property p_hold;
    cmd_strobe && !cmd_accepted |=> cmd_strobe;
  endproperty
  a_hold: assert property (p_hold) else $error("strobe dropped early");
  property p_off;
    cmd_strobe && cmd_accepted |=> !cmd_strobe && !data_accepted_n;
  endproperty
  a_off: assert property (p_off) else $error("strobe not ended");
  property p_set;
    $rose(cmd_strobe) |-> $past(cmd_ready_to_unit);
  endproperty
  a_set: assert property (p_set) else $error("strobe without ready");
  property p_da;
    $rose(data_here_n) |-> ##[1:4] data_accepted_n;
  endproperty
  a_da: assert property (p_da) else $error("accepted not dropped");
  property p_cmd;
    $fell(data_accepted_n) && test_external_instr_n |-> $past(cmd_accepted);
  endproperty
  a_cmd: assert property (p_cmd) else $error("accepted before device");
endmodule // ict_properties
bind ict_terminal ict_properties u_props (.mclk(mclk), .rst_n(rst_n),
  .instr_sync_n(instr_sync_n), .test_external_instr_n(test_external_instr_n),
  .data_here_n(data_here_n), .test_return_n(test_return_n), .sync_return_n(sync_return_n),
  .data_accepted_n(data_accepted_n), .unit_ready(unit_ready), .cmd_accepted(cmd_accepted),
  .cmd_ready_to_unit(cmd_ready_to_unit), .cmd_strobe(cmd_strobe));

// ==== verif/ict_mainframe.sv ====
// mainframe model sequencing command and test instructions
`timescale 1ns/1ps
module ict_mainframe (
  input wire mclk,
  input wire go,
  input wire tst,
  input wire wt,
  input wire [5:0] unit,
  input wire [15:0] word,
  input wire test_return_n,
  input wire sync_return_n,
  input wire data_accepted_n,
  output reg instr_sync_n = 1'b1,
  output reg command_external_instr_n = 1'b1,
  output reg test_external_instr_n = 1'b1,
  output reg wait_flag_n = 1'b1,
  output reg data_here_n = 1'b1,
  output reg [5:0] unit_number_n = 6'h3f,
  output reg [15:0] io_bus_n = 16'h0000,
  output reg done = 1'b0,
  output reg skip = 1'b0
);
  reg t;
  always @(posedge mclk) begin
    done <= 1'b0;
    if (go) begin
      command_external_instr_n <= tst;
      test_external_instr_n <= !tst;
      wait_flag_n <= !wt | tst;
      unit_number_n <= ~unit;
      @(posedge mclk);
      instr_sync_n <= 1'b0;
      while (sync_return_n) @(posedge mclk);
      t = !test_return_n;
      instr_sync_n <= 1'b1;
      while (!sync_return_n) @(posedge mclk);
      if (tst | t) begin
        io_bus_n <= ~word;
        data_here_n <= 1'b0;
        @(posedge mclk);
        while (data_accepted_n) @(posedge mclk);
        if (tst) t = !test_return_n;
        data_here_n <= 1'b1;
        // released bus shows the inverse, not a stale word
        io_bus_n <= word;
        while (!data_accepted_n) @(posedge mclk);
      end
      command_external_instr_n <= 1'b1;
      test_external_instr_n <= 1'b1;
      wait_flag_n <= 1'b1;
      unit_number_n <= unit;
      skip <= t;
      done <= 1'b1;
    end
  end
endmodule // ict_mainframe

// ==== verif/ict_terminal_test.sv ====
// self-checking bench for the command and test terminal
`timescale 1ns/1ps
module ict_terminal_test;
  reg mclk = 0, rst_n = 0, go = 0, tst = 0, wt = 0, unit_ready = 0, cmd_accepted = 0;
  reg [7:0] test_cond = 0;
  reg [15:0] word = 0;
  reg [3:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0, lastf = 0;
  reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire isn, cen, ten, wfn, dhn, trn, srn, dan, crdy, cstb, awr, wr_rdy, bv, arr, rv, dn, skp;
  wire [5:0] unn, fc;
  wire [15:0] bus_n;
  wire [2:0] su;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  reg [31:0] expq[$];
  integer miscompares = 0, checks = 0, i;
  always #25 mclk = ~mclk;
  ict_mainframe mf (.mclk(mclk), .go(go), .tst(tst), .wt(wt), .unit(6'h2d), .word(word),
    .test_return_n(trn), .sync_return_n(srn), .data_accepted_n(dan), .instr_sync_n(isn),
    .command_external_instr_n(cen), .test_external_instr_n(ten), .wait_flag_n(wfn),
    .data_here_n(dhn), .unit_number_n(unn), .io_bus_n(bus_n), .done(dn), .skip(skp));
  ict_terminal uut (.mclk(mclk), .rst_n(rst_n), .instr_sync_n(isn),
    .command_external_instr_n(cen), .test_external_instr_n(ten), .wait_flag_n(wfn),
    .data_here_n(dhn), .unit_number_n(unn), .io_bus_n(bus_n), .test_return_n(trn),
    .sync_return_n(srn), .data_accepted_n(dan), .unit_ready(unit_ready),
    .cmd_accepted(cmd_accepted), .test_cond(test_cond), .cmd_ready_to_unit(crdy),
    .cmd_strobe(cstb), .function_code(fc), .sub_unit(su), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rready));
  task chk(input [31:0] got);
    reg [31:0] e;
    begin
      e = expq.pop_front();
      checks = checks + 1;
      if (got !== e) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, e);
      end
    end
  endtask
  // ****************************************
  // result watcher and device stand-in
  // ****************************************
  always @(posedge mclk) begin
    if (bv && bready) chk({30'h0, bresp});
    if (rv && rready) chk(rdata);
    if ($rose(cstb)) chk({23'h0, su, fc});
    if (dn) chk({31'h0, skp});
  end
  // the device stalls a random while before taking the bits; a counter keeps
  // the watcher above free of waits
  reg [2:0] stall = 3'h0;
  always @(posedge mclk) begin
    if (cstb && !cmd_accepted) begin
      if (stall == 3'h0) cmd_accepted <= 1'b1;
      else stall <= stall - 3'h1;
    end else begin
      if (!cstb) cmd_accepted <= 1'b0;
      stall <= 3'($urandom % 6);
    end
  end
  task wr(input [3:0] a, input [31:0] d);
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      expq.push_back(32'h0);
      do begin
        @(posedge mclk);
        if (awvalid && awr) awvalid <= 1'b0;
        if (wvalid && wr_rdy) wvalid <= 1'b0;
      end while (!bv);
      bready <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      expq.push_back(e);
      do begin
        @(posedge mclk);
        if (arvalid && arr) arvalid <= 1'b0;
      end while (!rv);
      rready <= 1'b0;
    end
  endtask
  task run(input t, input w, input [7:0] rdy_at, input [2:0] ix, input e);
    reg [15:0] v;
    reg [7:0] c;
    integer n;
    begin
      v = $urandom;
      c = $urandom;
      if (t) v[8:6] = ix;
      tst <= t;
      wt <= w;
      word <= v;
      test_cond <= c;
      unit_ready <= (rdy_at == 0);
      go <= 1'b1;
      if (!t && rdy_at != 255) lastf = {23'h0, v[5:3], v[11:6]};
      if (!t && rdy_at != 255) expq.push_back(lastf);
      expq.push_back(t ? c[v[8:6]] : e);
      @(posedge mclk);
      go <= 1'b0;
      n = 0;
      while (!dn) begin
        @(posedge mclk);
        n = n + 1;
        if (n == rdy_at) unit_ready <= 1'b1;
      end
    end
  endtask
  task wrap_up;
    begin
      // a note that never met its result is a miss as well
      if (expq.size() != 0) miscompares = miscompares + 1;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    #400000;
    miscompares = miscompares + 1;
    wrap_up;
  end
  initial begin
    i = $urandom(32'h96fb84cb);
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(4'hc, 32'h0);
    rd(4'h8, 32'h0);
    wr(4'h4, 32'h2d);
    wr(4'h0, 32'h1);
    rd(4'h4, 32'h2d);
    rd(4'h0, 32'h1);
    run(0, 0, 0, 0, 1);
    run(0, 0, 255, 0, 0);
    run(0, 1, 20, 0, 1);
    rd(4'hc, lastf);
    for (i = 0; i < 8; i = i + 1) run(1, 0, 0, i[2:0], 0);
    // let the watcher take the last done pulse before closing
    repeat (2) @(posedge mclk);
    wrap_up;
  end
endmodule // ict_terminal_test
